// file: adc_defines.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef ADC_DEFINES_SVH
`define ADC_DEFINES_SVH

`define ADDR_MODE        3'h0
`define ADDR_CHSEL       3'h1
`define ADDR_PORTCFG     3'h2
`define ADDR_RES_FULL    3'h3
`define ADDR_RES_HIGH    3'h4
`define ADDR_IRQ_FLAG    3'h5
`define ADDR_STATUS      3'h6

`define MODE_START_BIT   7
`define MODE_ENABLE_BIT  0
`define MODE_SPEED_HI    5
`define MODE_SPEED_LO    1
`define CHSEL_MSB        1
`define PORTCFG_MSB      2
`define IRQ_FLAG_BIT     0

`define MODE_RESET       8'h00
`define CHSEL_RESET      2'h0
`define PORTCFG_RESET    3'h0
`define RESULT_RESET     10'h000

`define CLK_MHZ          50
`define ENABLE_SETTLE_NS 1000
`define ENABLE_SETTLE_CYCLES \
    ((`ENABLE_SETTLE_NS * `CLK_MHZ + 999) / 1000)
`define SAMPLE_CYCLES    8
`define SETUP_CYCLES     2
`define CONV_STEP_CYCLES 4

`endif

// file: adc_pkg.sv
// Types shared by the converter control files.
package adc_pkg;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONV   = 2'b11,
        ST_DONE   = 2'b10
    } conv_state_t;

    typedef struct packed {
        logic [2:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } bus_req_t;

endpackage : adc_pkg

// file: adc_interval_timer.sv
// Down-counter that times one conversion step from a loaded length.
module adc_interval_timer #(
    parameter int WIDTH = 10
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] length,
    input  wire logic             halt,
    output logic                  expired
);

    logic [WIDTH-1:0] count_q;
    logic             running_q;

    if (WIDTH < 4) begin : g_width_check
        $error("adc_interval_timer: WIDTH too small");
    end

    always_ff @(posedge clk) begin
        if (reset || halt) begin
            count_q   <= '0;
            running_q <= 1'b0;
            expired   <= 1'b0;
        end else if (load) begin
            count_q   <= length;
            running_q <= 1'b1;
            expired   <= 1'b0;
        end else if (running_q && count_q <= WIDTH'(1)) begin
            running_q <= 1'b0;
            expired   <= 1'b1;
        end else begin
            count_q   <= count_q - WIDTH'(1);
            expired   <= 1'b0;
        end
    end

endmodule : adc_interval_timer

// file: adc_sequencer_result_control.sv
// Converter sequencing, result storage and conflict handling behind Avalon-MM.
`include "adc_defines.svh"

// Notes on behaviour
// R1: A result that completes while software reads the full or high-byte result is held and stored right after that read.
// R2: A result that completes while software writes mode, channel or port setup is dropped and raises no interrupt.
// R3: The conversion time follows mode bits 5 to 1, and start to completion also includes sampling and setup cycles.
// R4: Software waits at least 1 us between enabling the comparator and setting the start control.
// R5: Software may enable at any setup step, but if it skips enabling it discards the first result.
// R6: In stop mode the converter halts, and clearing the start and enable controls saves current.
// R7: After standby, software clears the conversion interrupt flag before restarting.
// R8: Software leaves the shared port pins alone while a conversion runs.
// R9: Writing the channel select does not clear the conversion interrupt flag.
// R10: Software writes zero to channel select bits 2 to 7.
// R11: The high-byte view returns the upper eight bits of the latest 10-bit result.
module adc_sequencer_result_control
    import adc_pkg::*;
#(
    parameter int RESULT_BITS = 10,
    parameter int TIME_BITS   = 10
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        stop_mode,
    input  wire logic [RESULT_BITS-1:0] sar_code,
    output logic             sample_hold,
    output logic [1:0]       analog_channel,
    output logic             comparator_on,
    output logic             conversion_done_irq,
    output logic             enable_settled
);

    if (RESULT_BITS != 10) begin : g_result_bits_check
        $error("adc_sequencer_result_control: RESULT_BITS must be 10");
    end
    if (TIME_BITS < 8) begin : g_time_bits_check
        $error("adc_sequencer_result_control: TIME_BITS too small");
    end
    if (`ENABLE_SETTLE_CYCLES > 255) begin : g_settle_check
        $error("adc_sequencer_result_control: settle count exceeds counter");
    end

    bus_req_t req;
    assign req = '{avs_address, avs_read, avs_write, avs_writedata};

    logic [7:0]             converter_mode_reg_q;
    logic [1:0]             input_channel_select_q;
    logic [2:0]             analog_port_config_q;
    logic [RESULT_BITS-1:0] conv_result_full_q;
    logic                   conversion_irq_flag_q;
    logic [RESULT_BITS-1:0] pending_q;
    logic                   pending_valid_q;
    logic                   ack_q;
    logic                   waitrequest_q;
    logic [31:0]            rdata_q;
    conv_state_t            state_q;
    conv_state_t            state_d;
    logic                   first_q;
    logic [7:0]             settle_q;
    logic                   stop_s1_q;
    logic                   stop_s2_q;
    logic                   stop_s3_q;
    logic                   stopped_q;

    function automatic logic [TIME_BITS-1:0] conv_length(
        input logic [4:0] speed
    );
        conv_length = (TIME_BITS'(speed) + TIME_BITS'(1'h1))
                      * TIME_BITS'(`CONV_STEP_CYCLES);
    endfunction : conv_length

    function automatic logic addr_hit(
        input logic [2:0] addr,
        input logic [2:0] target
    );
        addr_hit = addr == target;
    endfunction : addr_hit

    // The stop level passes three flops and counts once the last two agree.
    always_ff @(posedge clk) begin
        if (reset) begin
            stop_s1_q <= 1'b0;
            stop_s2_q <= 1'b0;
            stop_s3_q <= 1'b0;
            stopped_q <= 1'b0;
        end else begin
            stop_s1_q <= stop_mode;
            stop_s2_q <= stop_s1_q;
            stop_s3_q <= stop_s2_q;
            if (stop_s2_q == stop_s3_q) begin
                stopped_q <= stop_s3_q;
            end
        end
    end

    // A request is taken only while no answer stands, so each has one wait.
    wire access    = (req.read || req.write) && !ack_q;
    wire wr        = req.write && access;
    wire rd        = req.read && access;
    wire wr_mode   = wr && addr_hit(req.address, `ADDR_MODE);
    wire wr_chsel  = wr && addr_hit(req.address, `ADDR_CHSEL);
    wire wr_port   = wr && addr_hit(req.address, `ADDR_PORTCFG);
    wire wr_flag   = wr && addr_hit(req.address, `ADDR_IRQ_FLAG);
    wire wr_config = wr_mode || wr_chsel || wr_port;
    wire rd_result = rd && (addr_hit(req.address, `ADDR_RES_FULL)
                         || addr_hit(req.address, `ADDR_RES_HIGH));

    wire start_ctl  = converter_mode_reg_q[`MODE_START_BIT];
    wire enable_ctl = converter_mode_reg_q[`MODE_ENABLE_BIT];
    wire [4:0] speed =
        converter_mode_reg_q[`MODE_SPEED_HI:`MODE_SPEED_LO];

    logic timer_load;
    logic [TIME_BITS-1:0] timer_len;
    logic timer_done;
    wire  halt = stopped_q || !start_ctl;  // see R6

    adc_interval_timer #(.WIDTH(TIME_BITS)) u_timer (
        .clk     (clk),
        .reset   (reset),
        .load    (timer_load),
        .length  (timer_len),
        .halt    (halt),
        .expired (timer_done)
    );

    always_comb begin
        state_d    = state_q;
        timer_load = 1'b0;
        timer_len  = TIME_BITS'(`SAMPLE_CYCLES);
        case (state_q)
            ST_IDLE: begin
                if (!halt) begin
                    state_d    = ST_SAMPLE;
                    timer_load = 1'b1;
                    timer_len  = TIME_BITS'(`SAMPLE_CYCLES + `SETUP_CYCLES);
                end
            end
            ST_SAMPLE: begin
                if (timer_done) begin
                    state_d    = ST_CONV;
                    timer_load = 1'b1;
                    timer_len  = conv_length(speed);  // see R3
                end
            end
            ST_CONV: begin
                if (timer_done) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (halt) begin
            state_d = ST_IDLE;
        end
    end

    // A configuration write at the end of a conversion drops that result.
    wire conv_end   = state_q == ST_DONE && !halt;
    wire keep_new   = conv_end && !wr_config;  // see R2
    wire store_now  = keep_new && !rd_result;
    wire store_late = pending_valid_q && !rd_result;  // see R1

    // The state register; halt sends the sequence back to idle.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            converter_mode_reg_q   <= `MODE_RESET;
            input_channel_select_q <= `CHSEL_RESET;
            analog_port_config_q   <= `PORTCFG_RESET;
        end else begin
            if (wr_mode) begin
                converter_mode_reg_q <= req.writedata[7:0];
            end
            if (wr_chsel) begin
                input_channel_select_q <= req.writedata[`CHSEL_MSB:0];
            end
            if (wr_port) begin
                analog_port_config_q <= req.writedata[`PORTCFG_MSB:0];
            end
        end
    end

    // A result that ends during a result read waits one cycle in pending_q.
    always_ff @(posedge clk) begin
        if (reset) begin
            conv_result_full_q <= `RESULT_RESET;
            pending_q          <= `RESULT_RESET;
            pending_valid_q    <= 1'b0;
        end else begin
            if (store_now) begin
                conv_result_full_q <= sar_code;
            end else if (store_late) begin
                conv_result_full_q <= pending_q;  // see R1
            end
            if (keep_new && rd_result) begin
                pending_q       <= sar_code;
                pending_valid_q <= 1'b1;
            end else if (store_late) begin
                pending_valid_q <= 1'b0;
            end
        end
    end

    // A new result sets the flag even when software clears it that cycle.
    always_ff @(posedge clk) begin
        if (reset) begin
            conversion_irq_flag_q <= 1'b0;
        end else if (keep_new) begin
            conversion_irq_flag_q <= 1'b1;  // see R2
        end else if (wr_flag) begin
            conversion_irq_flag_q <= req.writedata[`IRQ_FLAG_BIT];  // see R9
        end
    end

    // Counts cycles since the comparator was enabled, up to the settle time.
    always_ff @(posedge clk) begin
        if (reset) begin
            first_q  <= 1'b1;
            settle_q <= 8'h00;
        end else begin
            if (!enable_ctl) begin
                settle_q <= 8'h00;
            end else if (settle_q < 8'(`ENABLE_SETTLE_CYCLES)) begin
                settle_q <= settle_q + 8'h01;
            end
            if (!start_ctl) begin
                first_q <= 1'b1;
            end else if (keep_new) begin
                first_q <= 1'b0;
            end
        end
    end

    wire settled = settle_q >= 8'(`ENABLE_SETTLE_CYCLES);  // see R4
    wire [7:0] high_byte =
        conv_result_full_q[RESULT_BITS-1:RESULT_BITS-8];  // see R11

    // Unmapped addresses read as zero.
    logic [31:0] read_mux;
    always_comb begin
        case (req.address)
            `ADDR_MODE:     read_mux = {24'h000000, converter_mode_reg_q};
            `ADDR_CHSEL:    read_mux = {30'h0, input_channel_select_q};
            `ADDR_PORTCFG:  read_mux = {29'h0, analog_port_config_q};
            `ADDR_RES_FULL: read_mux = {22'h0, conv_result_full_q};
            `ADDR_RES_HIGH: read_mux = {24'h000000, high_byte};
            `ADDR_IRQ_FLAG: read_mux = {31'h0, conversion_irq_flag_q};
            `ADDR_STATUS:   read_mux = {27'h0, first_q, settled,
                                        stopped_q, state_q};
            default:        read_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ack_q               <= 1'b0;
            waitrequest_q       <= 1'b1;
            rdata_q             <= 32'h00000000;
            sample_hold         <= 1'b0;
            analog_channel      <= 2'h0;
            comparator_on       <= 1'b0;
            conversion_done_irq <= 1'b0;
            enable_settled      <= 1'b0;
        end else begin
            ack_q               <= access;
            waitrequest_q       <= !access;
            if (rd) begin
                rdata_q <= read_mux;
            end
            sample_hold         <= state_d == ST_SAMPLE;
            analog_channel      <= input_channel_select_q;
            comparator_on       <= enable_ctl && !stopped_q;  // see R6
            conversion_done_irq <= keep_new;
            enable_settled      <= settled;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = waitrequest_q;

endmodule : adc_sequencer_result_control

// file: adc_sequencer_result_control_properties.sv
// Port-level checks for the converter control block.
module adc_sequencer_result_control_properties
    import adc_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [2:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        stop_mode,
    input wire logic        sample_hold,
    input wire logic [1:0]  analog_channel,
    input wire logic        comparator_on,
    input wire logic        conversion_done_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] stop_q;
    always_ff @(posedge clk) begin
        if (reset || !stop_mode) begin
            stop_q <= 4'h0;
        end else if (stop_q != 4'hF) begin
            stop_q <= stop_q + 4'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence req_s; avs_read || avs_write; endsequence
    sequence taken_s; req_s ##0 avs_waitrequest; endsequence
    sequence done_s; req_s ##0 !avs_waitrequest; endsequence
    AST_ONE_WAIT: assert property (taken_s |=> !avs_waitrequest)
        else $error("request not answered after one wait");
    AST_ACK_ONE_CYCLE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer stood longer than one cycle");
    AST_NO_IDLE_ACK: assert property (!(avs_read || avs_write)
        |=> avs_waitrequest) else $error("answer without request");
    AST_HIGH_BYTE_UPPER: assert property (
        done_s ##0 (avs_read && avs_address == 3'h4)
        |-> avs_readdata[31:8] == 24'h000000)
        else $error("high byte view wider than eight bits");
    AST_UNMAPPED_ZERO: assert property (
        done_s ##0 (avs_read && avs_address == 3'h7)
        |-> avs_readdata == 32'h00000000) else $error("unmapped read");
    AST_CHAN_COPY: assert property (
        done_s ##0 (avs_write && avs_address == 3'h1)
        |=> analog_channel == $past(avs_writedata[1:0]))
        else $error("channel output not following select");
    AST_IRQ_SPACING: assert property (
        conversion_done_irq |=> !conversion_done_irq [*8])
        else $error("conversion shorter than sample and convert");
    AST_STOP_HALT: assert property (
        stop_q >= 4'h6 |-> !conversion_done_irq && !sample_hold
        && !comparator_on) else $error("converter active in stop");
endmodule : adc_sequencer_result_control_properties

// file: tb_adc_sequencer_result_control.sv
// Self-checking bench for the converter control block.
module tb_adc_sequencer_result_control import adc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        stop_mode = 1'b0;
    logic [9:0]  sar_code = 10'h000;
    bus_req_t    req = '0;
    logic [31:0] avs_readdata;
    logic [31:0] rd;
    logic [31:0] seed = 32'hD211A3EE;
    logic        avs_waitrequest;
    logic        sample_hold;
    logic        comparator_on;
    logic        irq;
    logic        settled;
    logic [1:0]  analog_channel;
    int          n_mismatch, samples_checked, n_irq, cyc, p0, p3, m;
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) n_irq <= n_irq + 1;
    end
    adc_sequencer_result_control dut (
        .clk(clk), .reset(reset), .avs_address(req.address),
        .avs_read(req.read), .avs_write(req.write),
        .avs_writedata(req.writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode),
        .sar_code(sar_code), .sample_hold(sample_hold),
        .analog_channel(analog_channel), .comparator_on(comparator_on),
        .conversion_done_irq(irq), .enable_settled(settled));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function automatic int conv_cycles(input int speed);
        return (speed + 1) * 4;
    endfunction : conv_cycles
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic hang;
        n_mismatch++;
        $display("Error at %0t: wait ran out", $time);
        tally_and_finish();
    endtask : hang
    task automatic bus(input logic [2:0] a, input logic w,
                       input logic [31:0] d);
        int i;
        i = 0;
        req <= '{a, !w, w, d};
        do begin
            @(posedge clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 20);
        if (avs_waitrequest !== 1'b0) hang();
        rd = avs_readdata;
        req <= '0;
        @(posedge clk);
    endtask : bus
    task automatic wait_irq;
        int b, i;
        b = n_irq;
        for (i = 0; i < 500 && n_irq == b; i++) @(posedge clk);
        if (n_irq == b) hang();
    endtask : wait_irq
    task automatic period(output int p);
        int t;
        wait_irq();
        t = cyc;
        wait_irq();
        p = cyc - t;
    endtask : period
    task automatic sweep(input logic [2:0] a, input logic w, output int miss);
        int k, b, t;
        miss = 0;
        for (k = 1; k <= 6; k++) begin
            wait_irq();
            b = n_irq;
            t = cyc;
            repeat (p0 - k) @(posedge clk);
            bus(a, w, 32'h0);
            while (cyc < t + 2 * p0 + p0 / 2) @(posedge clk);
            if (n_irq - b == 1) miss++;
        end
    endtask : sweep
    initial begin
        logic [9:0] c;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        check(32'(avs_waitrequest), 32'h1);
        bus(3'h0, 1'b0, 32'h0);
        check(rd, 32'h0);
        bus(3'h7, 1'b0, 32'h0);
        check(rd, 32'h0);
        $display("test reset ends");
        bus(3'h0, 1'b1, 32'h01);
        repeat (30) @(posedge clk);
        check(32'(settled), 32'h0);
        repeat (40) @(posedge clk);
        check(32'(settled), 32'h1);
        check(32'(comparator_on), 32'h1);
        bus(3'h1, 1'b1, 32'h2);
        check(32'(analog_channel), 32'h2);
        $display("test enable ends");
        bus(3'h0, 1'b1, 32'h81);
        for (int i = 0; i < 8; i++) begin
            wait_irq();
            check(32'(sample_hold), 32'h1);
            bus(3'h3, 1'b0, 32'h0);
            check(rd, 32'(sar_code));
            bus(3'h4, 1'b0, 32'h0);
            check(rd, 32'(sar_code[9:2]));
            seed = xs(seed);
            c = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : seed[9:0];
            sar_code <= c;
        end
        $display("test results ends");
        wait_irq();
        bus(3'h0, 1'b1, 32'h01);
        bus(3'h1, 1'b1, 32'h1);
        bus(3'h5, 1'b0, 32'h0);
        check(rd, 32'h1);
        bus(3'h5, 1'b1, 32'h0);
        bus(3'h5, 1'b0, 32'h0);
        check(rd, 32'h0);
        bus(3'h0, 1'b1, 32'h81);
        period(p0);
        sweep(3'h2, 1'b1, m);
        check(32'(m), 32'h1);
        sweep(3'h3, 1'b0, m);
        check(32'(m), 32'h0);
        $display("test conflicts ends");
        bus(3'h0, 1'b1, 32'h87);
        period(p3);
        period(p3);
        check(32'(p3 - p0), 32'(conv_cycles(3) - conv_cycles(0)));
        $display("test speed ends");
        stop_mode <= 1'b1;
        repeat (10) @(posedge clk);
        check(32'(comparator_on), 32'h0);
        m = n_irq;
        repeat (100) @(posedge clk);
        check(32'(n_irq - m), 32'h0);
        stop_mode <= 1'b0;
        bus(3'h5, 1'b1, 32'h0);
        bus(3'h0, 1'b1, 32'h81);
        wait_irq();
        bus(3'h5, 1'b0, 32'h0);
        check(rd, 32'h1);
        $display("test stop ends");
        bus(3'h0, 1'b1, 32'h00);
        bus(3'h0, 1'b1, 32'h80);
        bus(3'h6, 1'b0, 32'h0);
        check(rd & 32'h10, 32'h10);
        wait_irq();
        bus(3'h6, 1'b0, 32'h0);
        check(rd & 32'h10, 32'h0);
        check(32'(comparator_on), 32'h0);
        $display("test first result ends");
        tally_and_finish();
    end
endmodule : tb_adc_sequencer_result_control
bind adc_sequencer_result_control adc_sequencer_result_control_properties chk (
    .clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode),
    .sample_hold(sample_hold), .analog_channel(analog_channel),
    .comparator_on(comparator_on),
    .conversion_done_irq(conversion_done_irq));
